// File: eeprom_pkg.sv
// shared constants, state encodings and carrier structs for the eeprom slave
package eeprom_pkg;
    localparam int MEM_BYTES     = 2048;
    localparam int BLOCK_BYTES   = 256;
    localparam int BLOCKS        = 8;
    localparam int ADDR_W        = 11;
    localparam int PAGE_BYTES    = 16;
    localparam int MULTI_BYTES   = 8;
    localparam int BUF_CNT_W     = 5;
    localparam int TIMER_W       = 24;
    localparam int CLK_PERIOD_NS = 8;
    localparam int T_WR_NS       = 10_000_000;
    localparam int PROG_CYCLES   = T_WR_NS / CLK_PERIOD_NS;

    localparam logic [3:0] TYPE_CODE_DEFAULT = 4'h6; // arbitrary value
    localparam logic [ADDR_W-1:0] FLAG_BYTE_LO = 11'h0ff;
    localparam int FLAG_BIT      = 2;
    localparam int BIT_CNT_FULL  = 8;
    localparam int TX_LAST_FALL  = 7;

    localparam logic [31:0] CTRL_OFS    = 32'h0000_0000;
    localparam logic [31:0] STATUS_OFS  = 32'h0000_0004;
    localparam logic [31:0] COMMIT_OFS  = 32'h0000_0008;
    localparam logic        CTRL_ENABLE_RESET = 1'b1;
    localparam int STATUS_PTR_LSB = 16;
    localparam int STATUS_WN_LSB  = 4;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0]
    {
        ST_IDLE      = 4'h0,
        ST_DEV       = 4'h1,
        ST_DEV_ACK   = 4'h2,
        ST_ADDR      = 4'h3,
        ST_ADDR_ACK  = 4'h4,
        ST_WDATA     = 4'h5,
        ST_WDATA_ACK = 4'h6,
        ST_RDATA     = 4'h7,
        ST_RACK      = 4'h8
    } link_state_e;

    typedef struct packed
    {
        logic        awvalid;
        logic [31:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic        rready;
    } axil_req_s;

    typedef struct packed
    {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_s;

    typedef struct packed
    {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } wentry_s;
endpackage

// File: bit_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module bit_sync #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             core_clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed
    {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_s;

    sync_s state;
    sync_s next_state;

    always_comb
    begin
        next_state.meta   = async_in;
        next_state.stable = state.meta;
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            state <= '{meta: RESET_VAL, stable: RESET_VAL};
        else
            state <= next_state;
    end

    assign sync_out = state.stable;
endmodule

// File: prog_timer.sv
// self-timed programming cycle counter
`timescale 1ns/1ps
module prog_timer #(
    parameter int CYCLES = eeprom_pkg::PROG_CYCLES
) (
    input  wire logic core_clk_in,
    input  wire logic rst_in,
    input  wire logic start_in,
    output logic      busy_out,
    output logic      done_out
);
    typedef struct packed
    {
        logic                             busy;
        logic [eeprom_pkg::TIMER_W-1:0]   count;
    } timer_s;

    timer_s state;
    timer_s next_state;
    logic   last;

    assign last = state.busy
        && (state.count == eeprom_pkg::TIMER_W'(CYCLES - 1));

    always_comb
    begin
        next_state = state;
        if (last)
        begin
            next_state.busy  = 1'b0;
            next_state.count = '0;
        end
        else if (state.busy)
            next_state.count = state.count + 1'b1;
        else if (start_in)
        begin
            next_state.busy  = 1'b1;
            next_state.count = '0;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            state <= '0;
        else
            state <= next_state;
    end

    assign busy_out = state.busy;
    assign done_out = last;
endmodule

// File: i2c_eeprom_slave.sv
// two-wire serial eeprom slave with axi4-lite control and status
`timescale 1ns/1ps
module i2c_eeprom_slave #(
    parameter int         PROG_CYCLES   = eeprom_pkg::PROG_CYCLES,
    parameter logic [3:0] DEV_TYPE_CODE = eeprom_pkg::TYPE_CODE_DEFAULT,
    parameter bit         WRITE_CONTROL_VERSION = 1'b0
) (
    input  wire logic                  core_clk_in,
    input  wire logic                  rst_in,
    input  wire logic                  scl_in,
    input  wire logic                  sda_in,
    output logic                       sda_out,
    output logic                       sda_oe_out,
    input  wire logic                  mode_or_lock_in,
    input  wire logic                  protect_enable_in,
    input  wire logic                  protect_start_block_sel_lo_in,
    input  wire logic                  protect_start_block_sel_hi_in,
    input  wire eeprom_pkg::axil_req_s axil_req_in,
    output eeprom_pkg::axil_rsp_s      axil_rsp_out
);
    localparam int AW = eeprom_pkg::ADDR_W;
    localparam int BW = eeprom_pkg::BUF_CNT_W;

    typedef struct packed
    {
        eeprom_pkg::link_state_e st;
        logic [3:0]              cnt;
        logic [7:0]              shreg;
        logic                    rd;
        logic                    rd_nack;
        logic                    oe;
        logic [AW-1:0]           ptr;
        logic [BW-1:0]           wn;
        eeprom_pkg::wentry_s [eeprom_pkg::PAGE_BYTES-1:0] wbuf;
        logic [eeprom_pkg::MEM_BYTES-1:0][7:0] mem;
        logic                    scl_d;
        logic                    sda_d;
        logic                    enable;
        logic [15:0]             commits;
        logic                    aw_ok;
        logic [31:0]             awaddr;
        logic                    w_ok;
        logic [31:0]             wdata;
        logic [3:0]              wstrb;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    rvalid;
        logic [31:0]             rdata;
        logic [1:0]              rresp;
    } slave_s;

    slave_s        state;
    slave_s        next_state;
    logic [4:0]    pins;
    logic          scl;
    logic          sda;
    logic          mode_pin;
    logic          pre_pin;
    logic [1:0]    pb_pins;
    logic          busy;
    logic          done;
    logic          prog_start;
    logic          rise;
    logic          fall;
    logic          start_c;
    logic          stop_c;
    logic          hw_lock;
    logic          page_mode;
    logic [BW-1:0] limit;
    logic [AW-1:0] flag_addr;
    logic [7:0]    flag_byte;
    logic [AW-1:0] prot_start;
    logic          prot_on;

    // data and clock idle high on the bus, so reset the sync to high
    bit_sync #(
        .WIDTH     (5),
        .RESET_VAL (5'h03)
    ) u_pin_sync (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .async_in    ({protect_start_block_sel_hi_in,
                       protect_start_block_sel_lo_in,
                       protect_enable_in, scl_in, sda_in}),
        .sync_out    (pins)
    );

    bit_sync #(
        .WIDTH     (1),
        .RESET_VAL (1'b0)
    ) u_mode_sync (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .async_in    (mode_or_lock_in),
        .sync_out    (mode_pin)
    );

    prog_timer #(
        .CYCLES (PROG_CYCLES)
    ) u_timer (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .start_in    (prog_start),
        .busy_out    (busy),
        .done_out    (done)
    );

    assign sda     = pins[0];
    assign scl     = pins[1];
    assign pre_pin = pins[2];
    assign pb_pins = pins[4:3];

    assign rise    = scl && !state.scl_d;
    assign fall    = !scl && state.scl_d;
    assign start_c = scl && state.scl_d && state.sda_d && !sda;
    assign stop_c  = scl && state.scl_d && !state.sda_d && sda;

    assign hw_lock   = WRITE_CONTROL_VERSION && mode_pin;
    assign page_mode = WRITE_CONTROL_VERSION || !mode_pin;
    assign limit     = page_mode ? BW'(eeprom_pkg::PAGE_BYTES)
                                 : BW'(eeprom_pkg::MULTI_BYTES);

    // protection only ever reaches into the upper four blocks
    assign flag_addr  = {1'b1, pb_pins, eeprom_pkg::FLAG_BYTE_LO[7:0]};
    assign flag_byte  = state.mem[flag_addr];
    assign prot_start = {1'b1, pb_pins, flag_byte[7:4], 4'h0};
    assign prot_on    = pre_pin && flag_byte[eeprom_pkg::FLAG_BIT];

    always_comb
    begin
        logic [7:0]    rbyte;
        logic [AW-1:0] nptr;
        logic [31:0]   wmask;
        rbyte = state.mem[state.ptr];
        nptr  = state.ptr + 1'b1;
        wmask = '0;
        next_state       = state;
        prog_start       = 1'b0;
        next_state.scl_d = scl;
        next_state.sda_d = sda;

        if (done)
        begin
            for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++)
            begin
                if (BW'(i) < state.wn
                    && !(prot_on && state.wbuf[i].addr >= prot_start))
                    next_state.mem[state.wbuf[i].addr] = state.wbuf[i].data;
            end
            next_state.wn      = '0;
            next_state.commits = state.commits + 1'b1;
        end

        if (start_c)
        begin
            // a start seen during programming is ignored outright
            if (!busy && state.enable)
            begin
                next_state.st  = eeprom_pkg::ST_DEV;
                next_state.cnt = '0;
                next_state.oe  = 1'b0;
                next_state.wn  = '0;
            end
        end
        else if (stop_c)
        begin
            // bytes taken before a refused one are still programmed
            if (state.wn != '0 && !busy)
                prog_start = 1'b1;
            next_state.st = eeprom_pkg::ST_IDLE;
            next_state.oe = 1'b0;
        end
        else
        begin
            case (state.st)
                eeprom_pkg::ST_DEV,
                eeprom_pkg::ST_ADDR,
                eeprom_pkg::ST_WDATA:
                begin
                    if (rise)
                    begin
                        next_state.shreg = {state.shreg[6:0], sda};
                        next_state.cnt   = state.cnt + 1'b1;
                    end
                    else if (fall && state.cnt == 4'(eeprom_pkg::BIT_CNT_FULL))
                    begin
                        next_state.oe = 1'b1;
                        if (state.st == eeprom_pkg::ST_DEV)
                        begin
                            if (state.shreg[7:4] == DEV_TYPE_CODE
                                && !busy)
                            begin
                                next_state.ptr[10:8] = state.shreg[3:1];
                                next_state.rd = state.shreg[0];
                                next_state.st = eeprom_pkg::ST_DEV_ACK;
                            end
                            else
                            begin
                                next_state.oe = 1'b0;
                                next_state.st = eeprom_pkg::ST_IDLE;
                            end
                        end
                        else if (state.st == eeprom_pkg::ST_ADDR)
                        begin
                            next_state.ptr[7:0] = state.shreg;
                            next_state.st = eeprom_pkg::ST_ADDR_ACK;
                        end
                        else if (state.wn < limit && !hw_lock)
                        begin
                            next_state.wbuf[state.wn[3:0]] =
                                '{addr: state.ptr, data: state.shreg};
                            next_state.wn = state.wn + 1'b1;
                            // page mode rolls over inside its 16-byte page
                            if (page_mode)
                                next_state.ptr = {state.ptr[10:4], nptr[3:0]};
                            else
                                next_state.ptr = nptr;
                            next_state.st = eeprom_pkg::ST_WDATA_ACK;
                        end
                        else
                        begin
                            next_state.oe = 1'b0;
                            next_state.st = eeprom_pkg::ST_IDLE;
                        end
                    end
                end
                eeprom_pkg::ST_DEV_ACK,
                eeprom_pkg::ST_ADDR_ACK,
                eeprom_pkg::ST_WDATA_ACK:
                begin
                    if (fall)
                    begin
                        next_state.oe  = 1'b0;
                        next_state.cnt = '0;
                        if (state.st == eeprom_pkg::ST_DEV_ACK && state.rd)
                        begin
                            next_state.shreg = rbyte;
                            next_state.ptr   = nptr;
                            next_state.oe    = !rbyte[7];
                            next_state.st    = eeprom_pkg::ST_RDATA;
                        end
                        else if (state.st == eeprom_pkg::ST_DEV_ACK)
                            next_state.st = eeprom_pkg::ST_ADDR;
                        else
                            next_state.st = eeprom_pkg::ST_WDATA;
                    end
                end
                eeprom_pkg::ST_RDATA:
                begin
                    if (fall)
                    begin
                        next_state.cnt = state.cnt + 1'b1;
                        if (state.cnt == 4'(eeprom_pkg::TX_LAST_FALL))
                        begin
                            next_state.oe = 1'b0;
                            next_state.st = eeprom_pkg::ST_RACK;
                        end
                        else
                        begin
                            next_state.shreg = {state.shreg[6:0], 1'b0};
                            next_state.oe    = !state.shreg[6];
                        end
                    end
                end
                eeprom_pkg::ST_RACK:
                begin
                    if (rise)
                        next_state.rd_nack = sda;
                    else if (fall)
                    begin
                        if (!state.rd_nack)
                        begin
                            next_state.shreg = rbyte;
                            next_state.ptr   = nptr;
                            next_state.oe    = !rbyte[7];
                            next_state.cnt   = '0;
                            next_state.st    = eeprom_pkg::ST_RDATA;
                        end
                        else
                            next_state.st = eeprom_pkg::ST_IDLE;
                    end
                end
                default:
                    next_state.st = eeprom_pkg::ST_IDLE;
            endcase
        end

        // register bus: address and data taken in either order
        if (axil_req_in.awvalid && axil_rsp_out.awready)
        begin
            next_state.aw_ok  = 1'b1;
            next_state.awaddr = axil_req_in.awaddr;
        end
        if (axil_req_in.wvalid && axil_rsp_out.wready)
        begin
            next_state.w_ok  = 1'b1;
            next_state.wdata = axil_req_in.wdata;
            next_state.wstrb = axil_req_in.wstrb;
        end
        if (state.aw_ok && state.w_ok)
        begin
            wmask = {{8{state.wstrb[3]}}, {8{state.wstrb[2]}},
                     {8{state.wstrb[1]}}, {8{state.wstrb[0]}}};
            next_state.aw_ok  = 1'b0;
            next_state.w_ok   = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp  = eeprom_pkg::RESP_OKAY;
            if (state.awaddr == eeprom_pkg::CTRL_OFS)
            begin
                if (wmask[0])
                    next_state.enable = state.wdata[0];
            end
            else if (state.awaddr != eeprom_pkg::STATUS_OFS
                     && state.awaddr != eeprom_pkg::COMMIT_OFS)
                next_state.bresp = eeprom_pkg::RESP_SLVERR;
        end
        if (state.bvalid && axil_req_in.bready)
            next_state.bvalid = 1'b0;

        if (state.rvalid && axil_req_in.rready)
            next_state.rvalid = 1'b0;
        if (axil_req_in.arvalid && axil_rsp_out.arready)
        begin
            next_state.rvalid = 1'b1;
            next_state.rresp  = eeprom_pkg::RESP_OKAY;
            next_state.rdata  = '0;
            if (axil_req_in.araddr == eeprom_pkg::CTRL_OFS)
                next_state.rdata[0] = state.enable;
            else if (axil_req_in.araddr == eeprom_pkg::STATUS_OFS)
            begin
                next_state.rdata[0] = busy;
                next_state.rdata[1] = state.st != eeprom_pkg::ST_IDLE;
                next_state.rdata[eeprom_pkg::STATUS_WN_LSB +: BW] = state.wn;
                next_state.rdata[eeprom_pkg::STATUS_PTR_LSB +: AW] = state.ptr;
            end
            else if (axil_req_in.araddr == eeprom_pkg::COMMIT_OFS)
                next_state.rdata[15:0] = state.commits;
            else
                next_state.rresp = eeprom_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state        <= '0;
            state.st     <= eeprom_pkg::ST_IDLE;
            state.scl_d  <= 1'b1;
            state.sda_d  <= 1'b1;
            state.enable <= eeprom_pkg::CTRL_ENABLE_RESET;
        end
        else
            state <= next_state;
    end

    // open drain: only ever pull low
    assign sda_out    = 1'b0;
    assign sda_oe_out = state.oe;

    always_comb
    begin
        axil_rsp_out.awready = !state.aw_ok && !state.bvalid;
        axil_rsp_out.wready  = !state.w_ok && !state.bvalid;
        axil_rsp_out.bvalid  = state.bvalid;
        axil_rsp_out.bresp   = state.bresp;
        axil_rsp_out.arready = !state.rvalid;
        axil_rsp_out.rvalid  = state.rvalid;
        axil_rsp_out.rdata   = state.rdata;
        axil_rsp_out.rresp   = state.rresp;
    end
endmodule

// File: i2c_eeprom_slave_properties.sv
// assertion checker bound to the eeprom slave's ports
`timescale 1ns/1ps
module i2c_eeprom_slave_chk (
    input wire logic                  core_clk_in,
    input wire logic                  rst_in,
    input wire logic                  scl_in,
    input wire logic                  sda_out,
    input wire logic                  sda_oe_out,
    input wire eeprom_pkg::axil_req_s axil_req_in,
    input wire eeprom_pkg::axil_rsp_s axil_rsp_out
);
    logic aw_t;
    logic w_t;
    logic ar_t;
    assign aw_t = axil_req_in.awvalid & axil_rsp_out.awready;
    assign w_t  = axil_req_in.wvalid & axil_rsp_out.wready;
    assign ar_t = axil_req_in.arvalid & axil_rsp_out.arready;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    chk_open_drain: assert property (
        $rose(sda_oe_out) |-> !scl_in && sda_out == 1'b0)
        else $error("data pin pulled at wrong time");
    // moving data while scl is high would form a start or stop
    chk_sda_still: assert property (
        scl_in && $past(scl_in) |-> $stable(sda_oe_out))
        else $error("data moved during scl high");
    chk_b_answer: assert property (
        aw_t && w_t |-> ##2 axil_rsp_out.bvalid)
        else $error("write response late");
    chk_aw_block: assert property (aw_t |=> !axil_rsp_out.awready)
        else $error("write address taken twice");
    chk_b_clear: assert property (
        axil_rsp_out.bvalid && axil_req_in.bready |=> !axil_rsp_out.bvalid)
        else $error("write response kept");
    chk_r_answer: assert property (ar_t |=> axil_rsp_out.rvalid)
        else $error("read response late");
    chk_ar_block: assert property (
        axil_rsp_out.rvalid |-> !axil_rsp_out.arready)
        else $error("read taken while answering");
    chk_bad_read: assert property (
        ar_t && axil_req_in.araddr > eeprom_pkg::COMMIT_OFS |=>
        axil_rsp_out.rresp == eeprom_pkg::RESP_SLVERR &&
        axil_rsp_out.rdata == 32'h0)
        else $error("unmapped read not refused");
endmodule

bind i2c_eeprom_slave i2c_eeprom_slave_chk u_chk (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .scl_in(scl_in),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .axil_req_in(axil_req_in), .axil_rsp_out(axil_rsp_out));

// File: bus_master.sv
// behavioural two-wire bus master that clocks the eeprom slave
`timescale 1ns/1ps
module bus_master (
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_oe_out
);
    localparam int HALF = 32;
    initial
    begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    // also serves as restart from scl low
    // pin changes sit on falling core clock edges, 4 ns off the rising ones: no sampling race
    task automatic start();
        #(HALF / 2 - 4) sda_oe_out = 1'b0;
        #(HALF / 2) scl_out = 1'b1;
        #HALF sda_oe_out = 1'b1;
        #HALF scl_out = 1'b0;
        #4;
    endtask
    // sample late in high phase: slave output lags scl fall
    task automatic bit_io(input logic b, output logic s);
        #(HALF / 2 - 4) sda_oe_out = !b;
        #(HALF / 2) scl_out = 1'b1;
        #(HALF - 2) s = sda_in;
        #2 scl_out = 1'b0;
        #4;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask
    task automatic rbyte(input logic mack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(!mack, s);
    endtask
    task automatic stop();
        #(HALF / 2 - 4) sda_oe_out = 1'b1;
        #(HALF / 2) scl_out = 1'b1;
        #HALF sda_oe_out = 1'b0;
        #(HALF + 4);
    endtask
endmodule

// File: i2c_serial_eeprom_slave_bench.sv
// self-checking bench for the eeprom slave
`timescale 1ns/1ps
module i2c_serial_eeprom_slave_bench;
    localparam logic [3:0] CODE = 4'h5; // arbitrary value
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic mode = 1'b0;
    logic pen = 1'b0;
    logic scl;
    logic m_oe;
    logic d_oe;
    wire  sda = !(m_oe | d_oe);
    eeprom_pkg::axil_req_s req = '0;
    eeprom_pkg::axil_rsp_s rsp;
    int err_count = 0;
    int samples_checked = 0;
    initial
    begin
        forever #4 clk = !clk;
    end
    i2c_eeprom_slave #(.PROG_CYCLES(500), .DEV_TYPE_CODE(CODE))
    u_i2c_eeprom_slave (
        .core_clk_in(clk), .rst_in(rst), .scl_in(scl), .sda_in(sda),
        .sda_out(), .sda_oe_out(d_oe), .mode_or_lock_in(mode),
        .protect_enable_in(pen), .protect_start_block_sel_lo_in(pen),
        .protect_start_block_sel_hi_in(pen), .axil_req_in(req),
        .axil_rsp_out(rsp));
    bus_master u_bus_master (.sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));
    task automatic conclude();
        $display("mismatches %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, seen);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic guard(inout int n);
        n++;
        if (n > 200)
        begin
            err_count++;
            conclude();
        end
    endtask
    task automatic axi_wr(input logic [31:0] a, d, output logic [1:0] r);
        int n = 0;
        @(posedge clk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        do
        begin
            @(posedge clk);
            guard(n);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        r = rsp.bresp;
        req.bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        int n = 0;
        @(posedge clk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do
        begin
            @(posedge clk);
            guard(n);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
    endtask
    task automatic send(input logic [7:0] b, input logic exp);
        logic ack;
        u_bus_master.wbyte(b, ack);
        check("ack", {31'h0, exp}, {31'h0, ack});
    endtask
    task automatic recv(input logic mack, input logic [7:0] exp);
        logic [7:0] b;
        u_bus_master.rbyte(mack, b);
        check("rd byte", {24'h0, exp}, {24'h0, b});
    endtask
    task automatic point(input logic [2:0] blk, input logic [7:0] a);
        u_bus_master.start();
        send({CODE, blk, 1'b0}, 1'b1);
        send(a, 1'b1);
        u_bus_master.start();
        send({CODE, blk, 1'b1}, 1'b1);
    endtask
    task automatic settle(input logic [15:0] commits);
        logic [31:0] d;
        logic [1:0]  r;
        int n = 0;
        axi_rd(eeprom_pkg::STATUS_OFS, d, r);
        check("busy", 32'h1, {31'h0, d[0]});
        do
        begin
            guard(n);
            axi_rd(eeprom_pkg::STATUS_OFS, d, r);
        end while (d[0]);
        axi_rd(eeprom_pkg::COMMIT_OFS, d, r);
        check("commits", {16'h0, commits}, {16'h0, d[15:0]});
    endtask
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(eeprom_pkg::CTRL_OFS, d, r);
        check("ctrl", 32'h1, d);
        axi_rd(32'hc, d, r);
        check("bad rd", 32'h2, {30'h0, r});
        axi_wr(32'hc, 32'h0, r);
        check("bad wr", 32'h2, {30'h0, r});
        u_bus_master.start();
        send({~CODE, 3'd0, 1'b1}, 1'b0);
        u_bus_master.stop();
    endtask
    // page write wraps inside its 16-byte page, reads run on
    task automatic t_page();
        u_bus_master.start();
        send({CODE, 3'd5, 1'b0}, 1'b1);
        send(8'hfe, 1'b1);
        for (int i = 0; i < 3; i++) send(8'ha0 + 8'(i), 1'b1);
        u_bus_master.stop();
        u_bus_master.start();
        send({CODE, 3'd5, 1'b0}, 1'b0);
        u_bus_master.stop();
        settle(16'h1);
        point(3'd5, 8'hfe);
        recv(1'b1, 8'ha0);
        recv(1'b1, 8'ha1);
        recv(1'b0, 8'h00);
        u_bus_master.stop();
        point(3'd5, 8'hf0);
        recv(1'b0, 8'ha2);
        u_bus_master.stop();
    endtask
    task automatic t_multi();
        @(posedge clk);
        mode <= 1'b1;
        u_bus_master.start();
        send({CODE, 3'd2, 1'b0}, 1'b1);
        send(8'h10, 1'b1);
        for (int i = 0; i < 9; i++) send(8'h30 + 8'(i), i < 8);
        u_bus_master.stop();
        settle(16'h2);
        point(3'd2, 8'h10);
        for (int i = 0; i < 7; i++) recv(i < 6, 8'h30 + 8'(i));
        u_bus_master.stop();
        u_bus_master.start();
        send({CODE, 3'd2, 1'b1}, 1'b1);
        recv(1'b0, 8'h37);
        u_bus_master.stop();
    endtask
    // flag byte 0x7ff = 0xe4 arms protection from 0x7e0 once pin is high
    task automatic t_prot();
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk);
            pen <= k[0];
            u_bus_master.start();
            send({CODE, 3'd7, 1'b0}, 1'b1);
            send(k ? 8'he0 : 8'hff, 1'b1);
            send(k ? 8'h55 : 8'he4, 1'b1);
            u_bus_master.stop();
            settle(16'h3 + 16'(k));
        end
        point(3'd7, 8'he0);
        recv(1'b0, 8'h00);
        u_bus_master.stop();
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        t_regs();
        t_page();
        t_multi();
        t_prot();
        conclude();
    end
endmodule
